// file: hdl/eam_params.svh
/*
 * Constants of the exclusive access monitor: address windows, status codes, size codes.
 * Assumes it is included by the monitor files by bare name.
 */
`ifndef EAM_PARAMS_SVH
`define EAM_PARAMS_SVH

// Device windows of the default map that skip the global monitor unless the override is set
`define EAM_DEV0_LO      32'h4000_0000
`define EAM_DEV0_HI      32'h5fff_ffff
`define EAM_DEV1_LO      32'hc000_0000
`define EAM_DEV1_HI      32'hffff_ffff

// Store-exclusive status values
`define EAM_STATUS_PASS  1'h0
`define EAM_STATUS_FAIL  1'h1

// Access size codes
`define EAM_SIZE_BYTE    2'h0
`define EAM_SIZE_HALF    2'h1
`define EAM_SIZE_WORD    2'h2

`endif

// file: hdl/eam_pkg.sv
/*
 * Types of the exclusive access monitor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package eam_pkg;

    typedef enum logic [1:0] {
        EAM_OP_LOAD,
        EAM_OP_STORE,
        EAM_OP_CLEAR
    } eam_op_t;

    typedef enum logic [1:0] {
        EAM_ST_IDLE,
        EAM_ST_LOAD,
        EAM_ST_STORE
    } eam_state_t;

endpackage

// file: hdl/eam_lane_swap.sv
/*
 * Byte order conversion between register value and memory byte order.
 * Assumes data sits in the low lanes of a 32-bit word; purely combinational.
 */
`timescale 1ns/1ps
`include "eam_params.svh"

module eam_lane_swap (
    input  wire logic [1:0]  size,
    input  wire logic        big_endian,
    input  wire logic [31:0] din,
    output logic      [31:0] dout
);
    wire [31:0] word_rev = {din[7:0], din[15:8], din[23:16], din[31:24]};
    wire [31:0] half_rev = {16'h0000, din[7:0], din[15:8]};
    wire [31:0] be_val   = (size == `EAM_SIZE_WORD) ? word_rev :
                           (size == `EAM_SIZE_HALF) ? half_rev : {24'h000000, din[7:0]};
    wire [31:0] le_val   = (size == `EAM_SIZE_WORD) ? din :
                           (size == `EAM_SIZE_HALF) ? {16'h0000, din[15:0]} :
                                                      {24'h000000, din[7:0]};

    // Big-endian puts the msbyte at the lowest address [RULE_15]
    // Little-endian puts the lsbyte at the lowest address [RULE_16]
    assign dout = big_endian ? be_val : le_val;
endmodule

// file: hdl/eam_monitor.sv
/*
 * Local exclusive access monitor with bus exclusive signalling toward a global monitor.
 * Assumes the requester, the exception logic and the bus all run on ref_clk.
 */
`timescale 1ns/1ps
`include "eam_params.svh"

// What the document asks of this block, the system and software
// RULE_01 - Store-exclusive with tag held writes and returns status zero.
// RULE_02 - Store-exclusive without tag writes nothing and returns status one.
// RULE_03 - Load-exclusive reads the location and sets the local tag.
// RULE_04 - Byte, halfword and word sizes, plain and acquire/release forms.
// RULE_05 - Clear-exclusive drops only the local tag.
// RULE_06 - Every store-exclusive drops the local tag, pass or fail.
// RULE_07 - A taken exception drops the local tag.
// RULE_08 - The system tags shared locations in its global monitor.
// RULE_09 - Shareable store-exclusive may clear global tags in the system.
// RULE_10 - Default map device windows skip global monitor unless override set.
// RULE_11 - Exclusive accesses to shared regions raise the bus exclusive flag.
// RULE_12 - Override set: exclusive flag always raised.
// RULE_13 - Otherwise exclusive flag low and only the local tag counts.
// RULE_14 - Flag raised but no global monitor answer: store-exclusive fails.
// RULE_15 - Big-endian: msbyte at lowest byte address.
// RULE_16 - Little-endian: lsbyte at lowest byte address.
// RULE_17 - Software pairs loads and stores of matching size and form.
// RULE_18 - Software retries the whole sequence after a failed status.
// RULE_19 - Store passes locally only with tag set; reset clears tag.
module eam_monitor (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        op_valid,
    output logic             op_ready,
    input  eam_pkg::eam_op_t op_kind,
    input  wire logic [1:0]  op_size,
    input  wire logic        op_acq_rel,
    input  wire logic [31:0] op_addr,
    input  wire logic [31:0] op_wdata,
    input  wire logic        exception_taken,
    input  wire logic        external_exclusive_override,
    input  wire logic        mpu_enable,
    input  wire logic        mpu_shareable,
    input  wire logic        big_endian,
    output logic             bus_valid,
    output logic             bus_write,
    output logic [31:0]      bus_addr,
    output logic [1:0]       bus_size,
    output logic [31:0]      bus_wdata,
    output logic             bus_acq_rel,
    output logic             hexcl,
    input  wire logic        bus_done,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_exokay,
    output logic             resp_valid,
    output logic             resp_status,
    output logic [31:0]      resp_rdata,
    output logic             tag_set
);
    eam_pkg::eam_state_t state_q;
    eam_pkg::eam_state_t state_d;
    logic                tag_q;
    logic                tag_d;
    logic [1:0]          size_q;
    logic                be_q;
    logic [31:0]         mem_wdata;
    logic [31:0]         reg_rdata;

    function automatic logic in_dev_window(input logic [31:0] a);
        in_dev_window = (a >= `EAM_DEV0_LO && a <= `EAM_DEV0_HI) ||
                        (a >= `EAM_DEV1_LO && a <= `EAM_DEV1_HI);
    endfunction

    wire idle      = (state_q == eam_pkg::EAM_ST_IDLE);
    wire accept    = op_valid && idle;
    wire acc_load  = accept && (op_kind == eam_pkg::EAM_OP_LOAD);
    wire acc_store = accept && (op_kind == eam_pkg::EAM_OP_STORE);
    wire acc_clear = accept && (op_kind == eam_pkg::EAM_OP_CLEAR);
    wire size_ok   = (op_size == `EAM_SIZE_BYTE) || (op_size == `EAM_SIZE_HALF) ||
                     (op_size == `EAM_SIZE_WORD);

    // Shared under the MPU, or default map outside the device windows [RULE_10] [RULE_11]
    wire shared_ok = mpu_enable ? mpu_shareable : !in_dev_window(op_addr);
    // Override forces external signalling; else raised for shared regions, low and local only otherwise [RULE_12] [RULE_13]
    wire ext_excl  = external_exclusive_override || shared_ok;
    // Store issues a write only while the local tag is held [RULE_19] [RULE_01]
    wire st_write  = acc_store && tag_q;
    // External flag raised with no exclusive-okay answer fails the store [RULE_14]
    wire st_status = (hexcl && !bus_exokay) ? `EAM_STATUS_FAIL : `EAM_STATUS_PASS;

    assign op_ready = idle;
    assign tag_set  = tag_q;

    eam_lane_swap u_wswap (
        .size       (op_size),
        .big_endian (big_endian),
        .din        (op_wdata),
        .dout       (mem_wdata)
    );

    eam_lane_swap u_rswap (
        .size       (size_q),
        .big_endian (be_q),
        .din        (bus_rdata),
        .dout       (reg_rdata)
    );

    // Exception wins over a load accepted in the same cycle: the load still reads but the tag stays clear
    always_comb begin
        tag_d = tag_q;
        if (acc_load && size_ok) begin
            tag_d = 1'b1;                                    // [RULE_03] [RULE_04]
        end
        if (acc_store || acc_clear) begin
            tag_d = 1'b0;                                    // [RULE_05] [RULE_06]
        end
        if (exception_taken) begin
            tag_d = 1'b0;                                    // [RULE_07]
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            eam_pkg::EAM_ST_IDLE: begin
                if (acc_load) begin
                    state_d = eam_pkg::EAM_ST_LOAD;
                end else if (st_write) begin
                    state_d = eam_pkg::EAM_ST_STORE;
                end
            end
            eam_pkg::EAM_ST_LOAD,
            eam_pkg::EAM_ST_STORE: begin
                if (bus_done) begin
                    state_d = eam_pkg::EAM_ST_IDLE;
                end
            end
            default: begin
                state_d = eam_pkg::EAM_ST_IDLE;
            end
        endcase
    end

    // Reset leaves the tag clear so a first store fails [RULE_19]
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= eam_pkg::EAM_ST_IDLE;
            tag_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            tag_q   <= tag_d;
        end
    end

    // Bus request stays up until the bus reports completion
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_valid   <= 1'b0;
            bus_write   <= 1'b0;
            bus_addr    <= 32'h0000_0000;
            bus_size    <= 2'h0;
            bus_wdata   <= 32'h0000_0000;
            bus_acq_rel <= 1'b0;
            hexcl       <= 1'b0;
            size_q      <= 2'h0;
            be_q        <= 1'b0;
        end else if (acc_load || st_write) begin
            bus_valid   <= 1'b1;
            bus_write   <= acc_store;                        // [RULE_01]
            bus_addr    <= op_addr;
            bus_size    <= op_size;                          // [RULE_04]
            bus_wdata   <= mem_wdata;
            bus_acq_rel <= op_acq_rel;                       // [RULE_04]
            hexcl       <= ext_excl;                         // [RULE_11] [RULE_12] [RULE_13]
            size_q      <= op_size;
            be_q        <= big_endian;
        end else if (bus_done) begin
            bus_valid   <= 1'b0;
            bus_write   <= 1'b0;
            hexcl       <= 1'b0;
        end
    end

    // Status and data answer one cycle after the deciding edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            resp_valid  <= 1'b0;
            resp_status <= `EAM_STATUS_PASS;
            resp_rdata  <= 32'h0000_0000;
        end else begin
            resp_valid  <= 1'b0;
            if (acc_store && !tag_q) begin
                resp_valid  <= 1'b1;
                resp_status <= `EAM_STATUS_FAIL;             // [RULE_02]
            end else if (acc_clear) begin
                resp_valid  <= 1'b1;
                resp_status <= `EAM_STATUS_PASS;
            end else if (bus_done && state_q == eam_pkg::EAM_ST_STORE) begin
                resp_valid  <= 1'b1;
                resp_status <= st_status;                    // [RULE_01] [RULE_14]
            end else if (bus_done && state_q == eam_pkg::EAM_ST_LOAD) begin
                resp_valid  <= 1'b1;
                resp_status <= `EAM_STATUS_PASS;
                resp_rdata  <= reg_rdata;                    // [RULE_03]
            end
        end
    end

    a_store_no_tag: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_02]
        acc_store && !tag_q |=> resp_valid && resp_status && !bus_valid)
        else $error("store without tag did not fail cleanly");

    a_store_clears: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_06]
        acc_store |=> !tag_q)
        else $error("store-exclusive left the tag set");

    a_load_sets: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_03]
        acc_load && size_ok && !exception_taken |=> tag_q && bus_valid && !bus_write)
        else $error("load-exclusive did not set tag or read");

    a_clear_drops: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_05]
        acc_clear |=> !tag_q && !bus_valid)
        else $error("clear-exclusive left tag or touched bus");

    a_exc_drops: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_07]
        exception_taken |=> !tag_q)
        else $error("exception left the tag set");

    a_store_write: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_19]
        st_write |=> bus_valid && bus_write && bus_wdata == $past(mem_wdata))
        else $error("store with tag did not write");

    a_store_pass: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_01]
        state_q == eam_pkg::EAM_ST_STORE && bus_done && (!hexcl || bus_exokay)
        |=> resp_valid && !resp_status)
        else $error("held store did not report pass");

    a_ext_fail: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_14]
        state_q == eam_pkg::EAM_ST_STORE && bus_done && hexcl && !bus_exokay
        |=> resp_valid && resp_status)
        else $error("unmonitored external store did not fail");

    a_override_ext: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_12]
        (acc_load || st_write) && external_exclusive_override |=> hexcl)
        else $error("override set but exclusive flag low");

    a_dev_window: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_10]
        (acc_load || st_write) && !external_exclusive_override && !mpu_enable
        && in_dev_window(op_addr) |=> !hexcl)
        else $error("default device window raised exclusive flag");

    a_idle_low: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE_13]
        !bus_valid |-> !hexcl)
        else $error("exclusive flag up with no bus request");
endmodule

// file: verif/eam_global_mon.sv
/*
 * Behavioural global exclusive monitor and memory on the far side of the bus.
 * Assumes one request at a time from the monitor, all on ref_clk.
 */
`timescale 1ns/1ps

module eam_global_mon (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        slow,
    input  wire logic        no_mon,
    input  wire logic        bus_valid,
    input  wire logic        bus_write,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        hexcl,
    output logic             bus_done,
    output logic [31:0]      bus_rdata,
    output logic             bus_exokay
);
    logic [31:0] mem_q [0:15];
    logic        gtag_q;
    logic [2:0]  wait_q;
    logic        ok;

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem_q[i] = 32'h1234_5670 + 32'(i);
        end
    end

    // Exclusive store lands only with a live global tag
    assign ok = !hexcl || (!no_mon && gtag_q);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_done   <= 1'b0;
            bus_exokay <= 1'b0;
            bus_rdata  <= 32'h0;
            gtag_q     <= 1'b0;
            wait_q     <= 3'h0;
        end else begin
            bus_done   <= 1'b0;
            bus_exokay <= 1'b0;
            // Idle data toggles so a stale sample cannot pass
            bus_rdata  <= ~bus_rdata;
            if (bus_valid && !bus_done) begin
                wait_q <= wait_q + 3'h1;
                if (wait_q >= (slow ? 3'h4 : 3'h0)) begin
                    wait_q     <= 3'h0;
                    bus_done   <= 1'b1;
                    bus_exokay <= hexcl && !no_mon && (!bus_write || gtag_q);
                    if (bus_write) begin
                        gtag_q <= 1'b0;
                        if (ok) begin
                            mem_q[bus_addr[5:2]] <= bus_wdata;
                        end
                    end else begin
                        bus_rdata <= mem_q[bus_addr[5:2]];
                        gtag_q    <= hexcl && !no_mon;
                    end
                end
            end
        end
    end
endmodule

// file: verif/tb_top.sv
/*
 * Self-checking bench of the exclusive access monitor.
 * Assumes eam_global_mon stands in for the bus and its global monitor.
 */
`timescale 1ns/1ps

module tb_top;
    logic             ref_clk, nrst, op_valid, op_ready, op_acq_rel, exception_taken;
    logic             external_exclusive_override, mpu_enable, mpu_shareable, big_endian;
    logic             bus_valid, bus_write, bus_acq_rel, hexcl, bus_done, bus_exokay;
    logic             resp_valid, resp_status, tag_set, slow, no_mon, r_st, sb, sh, sa;
    logic [1:0]       op_size, bus_size, sz;
    logic [31:0]      op_addr, op_wdata, bus_addr, bus_wdata, bus_rdata, resp_rdata, r_rd, sw;
    eam_pkg::eam_op_t op_kind;
    int               miscompares, checks, cyc;

    eam_monitor u_eam_monitor (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid),
        .op_ready(op_ready), .op_kind(op_kind), .op_size(op_size), .op_acq_rel(op_acq_rel),
        .op_addr(op_addr), .op_wdata(op_wdata), .exception_taken(exception_taken),
        .external_exclusive_override(external_exclusive_override), .mpu_enable(mpu_enable),
        .mpu_shareable(mpu_shareable), .big_endian(big_endian), .bus_valid(bus_valid),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
        .bus_wdata(bus_wdata), .bus_acq_rel(bus_acq_rel), .hexcl(hexcl), .bus_done(bus_done),
        .bus_rdata(bus_rdata), .bus_exokay(bus_exokay), .resp_valid(resp_valid),
        .resp_status(resp_status), .resp_rdata(resp_rdata), .tag_set(tag_set));

    eam_global_mon u_eam_global_mon (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
        .no_mon(no_mon), .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .hexcl(hexcl), .bus_done(bus_done), .bus_rdata(bus_rdata),
        .bus_exokay(bus_exokay));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Bus qualifiers as the monitor presented them on its last access
    always @(posedge ref_clk) begin
        if (bus_valid) begin
            sb = 1'b1;
            sh = hexcl;
            sa = bus_acq_rel;
            sz = bus_size;
            sw = bus_wdata;
        end
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic op(input eam_pkg::eam_op_t k, input logic [1:0] sz, input logic ar,
                      input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        sb = 1'b0;
        op_valid   <= 1'b1;
        op_kind    <= k;
        op_size    <= sz;
        op_acq_rel <= ar;
        op_addr    <= a;
        op_wdata   <= d;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        do @(posedge ref_clk); while (resp_valid !== 1'b1);
        r_st = resp_status;
        r_rd = resp_rdata;
    endtask

    task automatic t_nostore();
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_0000, 32'h0);
        cmp(32'(r_st), 32'h1);
        cmp(32'(sb), 32'h0);
    endtask

    task automatic t_pairs();
        logic [31:0] m, a;
        for (int s = 0; s < 3; s++) begin
            for (int f = 0; f < 2; f++) begin
                a = 32'h2000_0004 + 32'(8 * s + 4 * f);
                m = (s == 0) ? 32'hff : (s == 1) ? 32'hffff : 32'hffff_ffff;
                op(eam_pkg::EAM_OP_LOAD, 2'(s), f[0], a, 32'h0);
                cmp(r_rd, (32'h1234_5671 + 32'(2 * s + f)) & m);
                cmp(32'(tag_set), 32'h1);
                cmp(32'(sa), 32'(f));
                cmp(32'(sz), 32'(s));
                // Store matches the load's size and form
                op(eam_pkg::EAM_OP_STORE, 2'(s), f[0], a, 32'hc0de_5a5a);
                cmp(32'(r_st), 32'h0);
                cmp(32'(tag_set), 32'h0);
                op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, a, 32'h0);
                cmp(r_rd, 32'hc0de_5a5a & m);
            end
        end
    endtask

    task automatic t_clear();
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_0024, 32'h0);
        op(eam_pkg::EAM_OP_CLEAR, 2'h2, 1'b0, 32'h0, 32'h0);
        cmp(32'(tag_set), 32'h0);
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_0024, 32'h0);
        cmp(32'(r_st), 32'h1);
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_0024, 32'h0);
        cmp(r_rd, 32'h1234_5679);
        exception_taken <= 1'b1;
        @(posedge ref_clk);
        exception_taken <= 1'b0;
        @(posedge ref_clk);
        cmp(32'(tag_set), 32'h0);
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_0024, 32'h0);
        cmp(32'(r_st), 32'h1);
        // Failed status: software repeats the whole sequence, which then lands
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_0024, 32'h0);
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_0024, 32'h5e3a_0001);
        cmp(32'(r_st), 32'h0);
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_0024, 32'h0);
        cmp(r_rd, 32'h5e3a_0001);
        // A size code outside byte, halfword and word must not arm the tag
        op(eam_pkg::EAM_OP_CLEAR, 2'h2, 1'b0, 32'h0, 32'h0);
        op(eam_pkg::EAM_OP_LOAD, 2'h3, 1'b0, 32'h2000_0024, 32'h0);
        cmp(32'(tag_set), 32'h0);
    endtask

    task automatic t_nomon();
        no_mon <= 1'b1;
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_002c, 32'h0);
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_002c, 32'h0);
        cmp(32'(r_st), 32'h1);
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_002c, 32'h0);
        cmp(r_rd, 32'h1234_567b);
        no_mon <= 1'b0;
    endtask

    task automatic hx(input logic ov, input logic me, input logic sr, input logic [31:0] a,
                      input logic e);
        external_exclusive_override <= ov;
        mpu_enable    <= me;
        mpu_shareable <= sr;
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, a, 32'h0);
        cmp(32'(sh), 32'(e));
    endtask

    task automatic t_region();
        hx(1'b0, 1'b0, 1'b0, 32'h4000_0000, 1'b0);
        hx(1'b0, 1'b0, 1'b0, 32'hc000_0000, 1'b0);
        hx(1'b0, 1'b0, 1'b0, 32'h6000_0000, 1'b1);
        hx(1'b1, 1'b0, 1'b0, 32'h5fff_fffc, 1'b1);
        hx(1'b0, 1'b1, 1'b1, 32'h4000_0000, 1'b1);
        hx(1'b0, 1'b1, 1'b0, 32'h2000_0000, 1'b0);
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_0000, 32'h0);
        cmp(32'(r_st), 32'h0);
        mpu_enable <= 1'b0;
    endtask

    task automatic t_endian();
        slow       <= 1'b1;
        big_endian <= 1'b1;
        op(eam_pkg::EAM_OP_LOAD, 2'h1, 1'b0, 32'h2000_0028, 32'h0);
        cmp(r_rd, 32'h0000_7a56);
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_0028, 32'h0);
        cmp(r_rd, 32'h7a56_3412);
        op(eam_pkg::EAM_OP_STORE, 2'h2, 1'b0, 32'h2000_0028, 32'h1122_3344);
        cmp(sw, 32'h4433_2211);
        big_endian <= 1'b0;
        op(eam_pkg::EAM_OP_LOAD, 2'h2, 1'b0, 32'h2000_0028, 32'h0);
        cmp(r_rd, 32'h4433_2211);
    endtask

    initial begin
        {nrst, op_valid, op_acq_rel, exception_taken, slow, no_mon} = '0;
        {external_exclusive_override, mpu_enable, mpu_shareable, big_endian} = '0;
        {op_size, op_addr, op_wdata, miscompares, checks, cyc} = '0;
        op_kind = eam_pkg::EAM_OP_CLEAR;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        cmp(32'(tag_set), 32'h0);
        t_nostore();
        t_pairs();
        t_clear();
        t_nomon();
        t_region();
        t_endian();
        end_sim();
    end
endmodule
